/* File: common/fdcr_pkg.sv */
// Package with register map, reset values and shared functions for the fine dc ranging block
package fdcr_pkg;
	localparam int DW = 24;
	localparam int AW = 56;
	localparam int SW = 32;
	localparam int NPATH = 4;
	localparam int NCHAN = 2;
	// Word indexes; the byte address is four times the index
	localparam logic [7:0] IDX_PNCTL = 8'h0A;
	localparam logic [7:0] IDX_SERCTL = 8'h21;
	localparam logic [7:0] IDX_RANGE = 8'h10;
	localparam logic [7:0] IDX_HOLDOFF = 8'h11;
	localparam logic [7:0] IDX_SYNC = 8'h12;
	localparam logic [7:0] IDX_BYPASS = 8'h13;
	localparam logic [7:0] IDX_SIG0 = 8'h14;
	localparam logic [7:0] IDX_EST0 = 8'h18;
	// Field positions
	localparam int PSEUDORANDOM_ENABLE_BIT = 1;
	localparam int ROUTE_N_BIT = 8;
	localparam int MINP_LSB = 0;
	localparam int LOWER_LSB = 8;
	localparam int UPPER_LSB = 16;
	// Reset values
	localparam logic [31:0] PNCTL_RST = 32'h0000_0000;
	localparam logic [31:0] SERCTL_RST = 32'h0000_0100;
	localparam logic [31:0] RANGE_RST = 32'h0014_0404;
	localparam logic [15:0] HOLDOFF_RST = 16'h0000;
	localparam logic [3:0] BYPASS_RST = 4'h0;
	localparam logic [23:0] PN_SEED = 24'hACE1B5;
	localparam logic [31:0] SIG_RST = 32'hFFFF_FFFF;
	localparam logic [5:0] EXP_MAX = 6'h1F;

	// Length of an integration for a given exponent
	function automatic logic [31:0] period(input logic [5:0] e);
		period = 32'h0000_0001 << ((e > EXP_MAX) ? EXP_MAX : e);
	endfunction

	// Level word in 6 dB steps: position of the top set bit plus one
	function automatic logic [4:0] level(input logic [23:0] m);
		level = 5'h00;
		for (int i = 0; i < 24; i++) begin
			if (m[i]) begin
				level = 5'(i + 1);
			end
		end
	endfunction
endpackage

/* File: logic/fdcr_path.sv */
// One path of the fine dc correction: peak detector, control counter, accumulator, subtractor
`timescale 1ns/1ps
module fdcr_path (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic in_valid,
	input wire logic [23:0] in_data,
	input wire logic [4:0] min_period,
	input wire logic [4:0] lower_thr,
	input wire logic [4:0] upper_thr,
	input wire logic bypass,
	output logic out_valid,
	output logic [23:0] out_data,
	output logic [23:0] estimate
);
	logic [55:0] acc_reg, acc_next;
	logic [23:0] est_reg, est_next, peak_reg, peak_next, out_reg, out_next;
	logic [31:0] cnt_reg, cnt_next;
	logic [5:0] exp_reg, exp_next;
	logic first_reg, first_next, ov_reg, ov_next;
	logic [23:0] mag, pk;
	logic [4:0] lvl;
	logic [5:0] tgt;
	logic [24:0] diff;

	always_comb begin
		mag = in_data[23] ? ((in_data == 24'h800000) ? 24'h7FFFFF : 24'(-in_data)) : in_data;
		pk = (mag > peak_reg) ? mag : peak_reg;
		lvl = fdcr_pkg::level(pk);
		tgt = (lvl > lower_thr) ? 6'({1'b0, min_period} + 6'({lvl - lower_thr, 1'b0})) : 6'(min_period);
		diff = {in_data[23], in_data} - {est_reg[23], est_reg};
		acc_next = acc_reg;
		est_next = est_reg;
		peak_next = peak_reg;
		cnt_next = cnt_reg;
		exp_next = exp_reg;
		first_next = first_reg;
		out_next = out_reg;
		ov_next = in_valid;
		if (in_valid) begin
			if (bypass) begin
				out_next = in_data;
			end else if (diff[24] != diff[23]) begin
				out_next = diff[24] ? 24'h800000 : 24'h7FFFFF;
			end else begin
				out_next = diff[23:0];
			end
			if (first_reg) begin
				first_next = 1'b0;
				peak_next = mag;
				acc_next = 56'(signed'(in_data));
				exp_next = 6'(min_period);
				cnt_next = fdcr_pkg::period(6'(min_period)) - 32'h1;
			end else if (lvl > upper_thr) begin
				acc_next = 56'(signed'(in_data));
				peak_next = mag;
				exp_next = 6'(min_period);
				cnt_next = fdcr_pkg::period(6'(min_period)) - 32'h1;
			end else if (cnt_reg == 32'h0) begin
				est_next = 24'(signed'(acc_reg) >>> exp_reg);
				acc_next = 56'(signed'(in_data));
				peak_next = mag;
				exp_next = 6'(min_period);
				cnt_next = fdcr_pkg::period(6'(min_period)) - 32'h1;
			end else begin
				acc_next = acc_reg + 56'(signed'(in_data));
				peak_next = pk;
				if (tgt > exp_reg) begin
					exp_next = tgt;
					cnt_next = cnt_reg - 32'h1 + fdcr_pkg::period(tgt) - fdcr_pkg::period(exp_reg);
				end else begin
					cnt_next = cnt_reg - 32'h1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			acc_reg <= 56'h0;
			est_reg <= 24'h0;
			peak_reg <= 24'h0;
			out_reg <= 24'h0;
			cnt_reg <= 32'h0;
			exp_reg <= 6'h0;
			first_reg <= 1'b1;
			ov_reg <= 1'b0;
		end else begin
			acc_reg <= acc_next;
			est_reg <= est_next;
			peak_reg <= peak_next;
			out_reg <= out_next;
			cnt_reg <= cnt_next;
			exp_reg <= exp_next;
			first_reg <= first_next;
			ov_reg <= ov_next;
		end
	end

	assign out_valid = ov_reg;
	assign out_data = out_reg;
	assign estimate = est_reg;
endmodule

/* File: logic/fdcr_sig.sv */
// Pseudorandom stimulus generator and signature register for one path
`timescale 1ns/1ps
module fdcr_sig (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic advance,
	input wire logic capture,
	input wire logic [23:0] data,
	output logic [23:0] pn,
	output logic [31:0] signature
);
	logic [23:0] pn_reg, pn_next;
	logic [31:0] sig_reg, sig_next;

	always_comb begin
		pn_next = pn_reg;
		sig_next = sig_reg;
		if (start) begin
			pn_next = fdcr_pkg::PN_SEED;
			sig_next = fdcr_pkg::SIG_RST;
		end else begin
			if (advance) begin
				pn_next = {pn_reg[22:0], pn_reg[23] ^ pn_reg[22] ^ pn_reg[21] ^ pn_reg[16]};
			end
			if (capture) begin
				sig_next = {sig_reg[30:0], sig_reg[31] ^ sig_reg[21] ^ sig_reg[1] ^ sig_reg[0]}
					^ {8'h00, data};
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pn_reg <= fdcr_pkg::PN_SEED;
			sig_reg <= fdcr_pkg::SIG_RST;
		end else begin
			pn_reg <= pn_next;
			sig_reg <= sig_next;
		end
	end

	assign pn = pn_reg;
	assign signature = sig_reg;
endmodule

/* File: logic/fdcr_top.sv */
// Top of the fine dc ranging and self-check block with its AHB-Lite register slave
`timescale 1ns/1ps
//
// Overview of operation
// - Below lower threshold, counter cycles minimum period
// - Above upper threshold, counter reloaded to minimum period, no update
// - Below upper again, counter counts down from minimum period
// - Between thresholds, period quadruples per 6 dB
// - Length is two to min plus twice steps
// - Self-check independent per channel, I and Q
// - Pseudorandom generator supplies self-check stimulus
// - Readable signature captures corrected path output
// - Each path's subtractor can be bypassed
// - Soft write or sync pin starts channels
// - Peak encoded in 6 dB steps
// - Counter zero updates estimate, restarts accumulator, peak
// - Separate detector, accumulator, counter per path
module fdcr_top #(
	parameter int NPATH = fdcr_pkg::NPATH
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic sync_pin,
	input wire logic in_valid,
	input wire logic [23:0] in_ai,
	input wire logic [23:0] in_aq,
	input wire logic [23:0] in_bi,
	input wire logic [23:0] in_bq,
	output logic out_valid,
	output logic [23:0] out_ai,
	output logic [23:0] out_aq,
	output logic [23:0] out_bi,
	output logic [23:0] out_bq,
	output logic [1:0] run
);
	logic [31:0] pnctl_reg, pnctl_next, serctl_reg, serctl_next, range_reg, range_next;
	logic [15:0] holdoff_reg, holdoff_next;
	logic [3:0] bypass_reg, bypass_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic [7:0] widx_reg, widx_next;
	logic wpend_reg, wpend_next;
	logic sync_d_reg, sync_d_next;
	logic [1:0] run_reg, run_next, arm_reg, arm_next, start_reg, start_next;
	logic [15:0] hcnt_reg [2];
	logic [15:0] hcnt_next [2];
	logic ov_reg, ov_next;
	logic [23:0] o_reg [4];
	logic [23:0] o_next [4];
	logic [23:0] src [4];
	logic [23:0] pin_smp [4];
	logic [23:0] pn [4];
	logic [23:0] pout [4];
	logic [23:0] est [4];
	logic [31:0] sig [4];
	logic pv [4];
	logic pvalid [4];
	logic take, pin_pulse, pseudorandom_enable;
	logic [1:0] sync_req;
	logic [7:0] ridx;

	assign pin_smp[0] = in_ai;
	assign pin_smp[1] = in_aq;
	assign pin_smp[2] = in_bi;
	assign pin_smp[3] = in_bq;
	assign pseudorandom_enable = pnctl_reg[fdcr_pkg::PSEUDORANDOM_ENABLE_BIT];

	// Register slave: zero wait states, read data registered in the address phase
	always_comb begin
		take = hsel && htrans[1] && hready;
		ridx = haddr[9:2];
		widx_next = take ? ridx : widx_reg;
		wpend_next = take && hwrite;
		hrdata_next = hrdata_reg;
		if (take && !hwrite) begin
			unique case (ridx)
				fdcr_pkg::IDX_PNCTL: hrdata_next = pnctl_reg;
				fdcr_pkg::IDX_SERCTL: hrdata_next = serctl_reg;
				fdcr_pkg::IDX_RANGE: hrdata_next = range_reg;
				fdcr_pkg::IDX_HOLDOFF: hrdata_next = {16'h0000, holdoff_reg};
				fdcr_pkg::IDX_SYNC: hrdata_next = {28'h0000000, arm_reg, run_reg};
				fdcr_pkg::IDX_BYPASS: hrdata_next = {28'h0000000, bypass_reg};
				8'h14, 8'h15, 8'h16, 8'h17: hrdata_next = sig[ridx[1:0]];
				8'h18, 8'h19, 8'h1A, 8'h1B: hrdata_next = {{8{est[ridx[1:0]][23]}}, est[ridx[1:0]]};
				default: hrdata_next = 32'h0000_0000;
			endcase
		end
		pnctl_next = pnctl_reg;
		serctl_next = serctl_reg;
		range_next = range_reg;
		holdoff_next = holdoff_reg;
		bypass_next = bypass_reg;
		sync_req = 2'b00;
		if (wpend_reg) begin
			unique case (widx_reg)
				fdcr_pkg::IDX_PNCTL: pnctl_next = hwdata & 32'h0000_0002;
				fdcr_pkg::IDX_SERCTL: serctl_next = hwdata & 32'h0000_01FF;
				fdcr_pkg::IDX_RANGE: range_next = hwdata & 32'h001F_1F1F;
				fdcr_pkg::IDX_HOLDOFF: holdoff_next = hwdata[15:0];
				fdcr_pkg::IDX_SYNC: sync_req = hwdata[1:0];
				fdcr_pkg::IDX_BYPASS: bypass_next = hwdata[3:0];
				default: sync_req = 2'b00;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pnctl_reg <= fdcr_pkg::PNCTL_RST;
			serctl_reg <= fdcr_pkg::SERCTL_RST;
			range_reg <= fdcr_pkg::RANGE_RST;
			holdoff_reg <= fdcr_pkg::HOLDOFF_RST;
			bypass_reg <= fdcr_pkg::BYPASS_RST;
			hrdata_reg <= 32'h0000_0000;
			widx_reg <= 8'h00;
			wpend_reg <= 1'b0;
		end else begin
			pnctl_reg <= pnctl_next;
			serctl_reg <= serctl_next;
			range_reg <= range_next;
			holdoff_reg <= holdoff_next;
			bypass_reg <= bypass_next;
			hrdata_reg <= hrdata_next;
			widx_reg <= widx_next;
			wpend_reg <= wpend_next;
		end
	end

	// Channel start: sync, holdoff count, then run with fresh stimulus and signature
	always_comb begin
		sync_d_next = sync_pin;
		pin_pulse = sync_pin && !sync_d_reg;
		run_next = run_reg;
		arm_next = arm_reg;
		start_next = 2'b00;
		for (int c = 0; c < 2; c++) begin
			hcnt_next[c] = hcnt_reg[c];
			if (!pseudorandom_enable) begin
				run_next[c] = 1'b0;
				arm_next[c] = 1'b0;
			end else if (sync_req[c] || pin_pulse) begin
				arm_next[c] = 1'b1;
				run_next[c] = 1'b0;
				hcnt_next[c] = holdoff_reg;
			end else if (arm_reg[c]) begin
				if (hcnt_reg[c] <= 16'h0001) begin
					arm_next[c] = 1'b0;
					run_next[c] = 1'b1;
					start_next[c] = 1'b1;
				end else begin
					hcnt_next[c] = hcnt_reg[c] - 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sync_d_reg <= 1'b0;
			run_reg <= 2'b00;
			arm_reg <= 2'b00;
			start_reg <= 2'b00;
			hcnt_reg[0] <= 16'h0000;
			hcnt_reg[1] <= 16'h0000;
		end else begin
			sync_d_reg <= sync_d_next;
			run_reg <= run_next;
			arm_reg <= arm_next;
			start_reg <= start_next;
			hcnt_reg[0] <= hcnt_next[0];
			hcnt_reg[1] <= hcnt_next[1];
		end
	end

	// One ranging path and one signature per path
	for (genvar p = 0; p < NPATH; p++) begin : g_path
		assign src[p] = run_reg[p / 2] ? pn[p] : pin_smp[p];
		assign pvalid[p] = run_reg[p / 2] ? 1'b1 : in_valid;

		fdcr_path u_path (
			.ref_clk(ref_clk),
			.rst(rst),
			.in_valid(pvalid[p]),
			.in_data(src[p]),
			.min_period(range_reg[fdcr_pkg::MINP_LSB +: 5]),
			.lower_thr(range_reg[fdcr_pkg::LOWER_LSB +: 5]),
			.upper_thr(range_reg[fdcr_pkg::UPPER_LSB +: 5]),
			.bypass(bypass_reg[p]),
			.out_valid(pv[p]),
			.out_data(pout[p]),
			.estimate(est[p])
		);

		fdcr_sig u_sig (
			.ref_clk(ref_clk),
			.rst(rst),
			.start(start_reg[p / 2]),
			.advance(run_reg[p / 2]),
			.capture(run_reg[p / 2] && pv[p] && !serctl_reg[fdcr_pkg::ROUTE_N_BIT]),
			.data(pout[p]),
			.pn(pn[p]),
			.signature(sig[p])
		);
	end

	// Output registers
	always_comb begin
		ov_next = pv[0];
		for (int p = 0; p < 4; p++) begin
			o_next[p] = pv[p] ? pout[p] : o_reg[p];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ov_reg <= 1'b0;
			for (int p = 0; p < 4; p++) begin
				o_reg[p] <= 24'h000000;
			end
		end else begin
			ov_reg <= ov_next;
			for (int p = 0; p < 4; p++) begin
				o_reg[p] <= o_next[p];
			end
		end
	end

	assign hrdata = hrdata_reg;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign out_valid = ov_reg;
	assign out_ai = o_reg[0];
	assign out_aq = o_reg[1];
	assign out_bi = o_reg[2];
	assign out_bq = o_reg[3];
	assign run = run_reg;
endmodule

/* File: sim/fdcr_src.sv */
// Sample source standing in for the channel filter output
`timescale 1ns/1ps
module fdcr_src (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic en,
	input wire logic [23:0] v,
	output logic in_valid,
	output logic [23:0] in_ai,
	output logic [23:0] in_aq,
	output logic [23:0] in_bi,
	output logic [23:0] in_bq,
	output int count
);
	logic ph;
	always_ff @(posedge ref_clk) begin
		if (rst || !en) begin
			ph <= 1'b0;
			count <= 0;
			in_valid <= 1'b0;
		end else begin
			ph <= ~ph;
			in_valid <= ~ph;
			if (!ph) begin
				count <= count + 1;
			end
		end
	end
	// Lines carry inverted values between strobes
	assign in_ai = in_valid ? v : ~v;
	assign in_aq = in_valid ? v + 24'h000002 : ~v;
	assign in_bi = in_valid ? 24'h000000 - v : ~v;
	assign in_bq = in_valid ? v + 24'h000004 : ~v;
endmodule

/* File: sim/fdcr_top_sva.sv */
// Port checker for the fine dc ranging block
`timescale 1ns/1ps
module fdcr_top_sva #(
	parameter int NPATH = 4
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic in_valid,
	input wire logic out_valid,
	input wire logic [23:0] out_ai,
	input wire logic [1:0] run
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic rd_go;
	assign rd_go = hsel && htrans[1] && hready && !hwrite;
	sequence sample_quiet;
		in_valid && run == 2'h0 ##1 run == 2'h0 ##1 run == 2'h0;
	endsequence
	sequence rd_unmapped;
		rd_go && haddr[9:2] == 8'hFF;
	endsequence
	chk_ready_const: assert property (hreadyout == 1'b1) else $error("hreadyout dropped");
	chk_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
	chk_valid_lat: assert property (sample_quiet |-> out_valid) else $error("out_valid late");
	chk_valid_cause: assert property (out_valid && run == 2'h0 && $past(run) == 2'h0 && $past(run, 2) == 2'h0
		|-> $past(in_valid, 2)) else $error("out_valid without sample");
	chk_out_hold: assert property (!out_valid && run == 2'h0 && $past(run) == 2'h0 |-> $stable(out_ai))
		else $error("out_ai moved between strobes");
	chk_run_valid: assert property (run[0] [*3] |-> out_valid) else $error("self check stream gap");
	chk_unmapped_read: assert property (rd_unmapped |=> hrdata == 32'h0) else $error("unmapped read nonzero");
	chk_hrdata_hold: assert property (!rd_go |=> $stable(hrdata)) else $error("hrdata moved");
endmodule
bind fdcr_top fdcr_top_sva #(.NPATH(NPATH)) fdcr_top_sva_inst (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hrdata, .hreadyout, .hresp, .in_valid, .out_valid, .out_ai, .run);

/* File: sim/tb.sv */
// Testbench for the fine dc ranging and self check block
`timescale 1ns/1ps
module tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic sync_pin = 1'b0;
	logic src_en = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [23:0] src_v = 24'h0;
	logic hready, hreadyout, hresp, in_valid, out_valid;
	logic [1:0] run;
	logic [31:0] hrdata, rd, sa, sb, sa2, sb2;
	logic [23:0] in_ai, in_aq, in_bi, in_bq, out_ai, out_aq, out_bi, out_bq;
	int src_cnt;
	int fail_count = 0;
	int n_compared = 0;
	always #4 ref_clk = ~ref_clk;
	assign hready = hreadyout;
	fdcr_top fdcr_top_inst (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
		.hreadyout, .hresp, .sync_pin, .in_valid, .in_ai, .in_aq, .in_bi, .in_bq, .out_valid, .out_ai, .out_aq,
		.out_bi, .out_bq, .run);
	fdcr_src fdcr_src_inst (.ref_clk, .rst, .en(src_en), .v(src_v), .in_valid, .in_ai, .in_aq, .in_bi, .in_bq,
		.count(src_cnt));
	task automatic tally_and_finish();
		if (fail_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_up();
		fail_count++;
		tally_and_finish();
	endtask
	task automatic wait_rdy();
		for (int n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (hready === 1'b1) begin
				return;
			end
		end
		give_up();
	endtask
	task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		haddr <= {22'h0, idx, 2'h0};
		wait_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		bus(1'b1, idx, d);
	endtask
	task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0);
		check(rd, exp);
	endtask
	task automatic feed(input logic [23:0] v, input int n);
		src_v <= v;
		src_en <= 1'b1;
		for (int k = 0; src_cnt < n; k++) begin
			if (k > 10 * n) begin
				give_up();
			end
			@(posedge ref_clk);
		end
		src_en <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic t_reset();
		rchk(fdcr_pkg::IDX_PNCTL, fdcr_pkg::PNCTL_RST);
		rchk(fdcr_pkg::IDX_SERCTL, fdcr_pkg::SERCTL_RST);
		rchk(fdcr_pkg::IDX_RANGE, fdcr_pkg::RANGE_RST);
		rchk(fdcr_pkg::IDX_HOLDOFF, {16'h0, fdcr_pkg::HOLDOFF_RST});
		rchk(fdcr_pkg::IDX_SIG0 + 8'h03, fdcr_pkg::SIG_RST);
		wr(8'hFF, 32'h1);
		rchk(8'hFF, 32'h0);
	endtask
	task automatic t_low();
		feed(24'h000003, 40);
		rchk(fdcr_pkg::IDX_EST0, 32'h3);
		rchk(fdcr_pkg::IDX_EST0 + 8'h01, 32'h5);
		rchk(fdcr_pkg::IDX_EST0 + 8'h02, 32'hFFFFFFFD);
		rchk(fdcr_pkg::IDX_EST0 + 8'h03, 32'h7);
		check({8'h0, out_ai}, 32'h0);
		check({8'h0, out_bi}, 32'h0);
		check({8'h0, out_aq}, 32'h0);
		check({8'h0, out_bq}, 32'h0);
	endtask
	task automatic t_high();
		wr(fdcr_pkg::IDX_RANGE, 32'h00040201);
		rchk(fdcr_pkg::IDX_RANGE, 32'h00040201);
		feed(24'h000100, 20);
		rchk(fdcr_pkg::IDX_EST0, 32'h3);
		check({8'h0, out_ai}, 32'h000000FD);
		feed(24'h000002, 48);
		rchk(fdcr_pkg::IDX_EST0, 32'h2);
		rchk(fdcr_pkg::IDX_EST0 + 8'h03, 32'h6);
	endtask
	task automatic t_bypass();
		wr(fdcr_pkg::IDX_BYPASS, 32'hF);
		rchk(fdcr_pkg::IDX_BYPASS, 32'hF);
		feed(24'h000009, 4);
		check({8'h0, out_ai}, 32'h9);
		check({8'h0, out_bi}, 32'h00FFFFF7);
		check({8'h0, out_aq}, 32'hB);
		check({8'h0, out_bq}, 32'hD);
		wr(fdcr_pkg::IDX_BYPASS, 32'h0);
	endtask
	task automatic selfrun(input logic pin, input int len, input logic [1:0] exp_run);
		int k;
		rst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		wr(fdcr_pkg::IDX_HOLDOFF, 32'h5);
		wr(fdcr_pkg::IDX_PNCTL, 32'h2);
		wr(fdcr_pkg::IDX_SERCTL, 32'h0);
		if (pin) begin
			sync_pin <= 1'b1;
			@(posedge ref_clk);
			sync_pin <= 1'b0;
		end else begin
			wr(fdcr_pkg::IDX_SYNC, 32'h1);
		end
		for (k = 0; run === 2'h0; k++) begin
			if (k > 50) begin
				give_up();
			end
			@(posedge ref_clk);
		end
		repeat (len) @(posedge ref_clk);
		check({30'h0, run}, {30'h0, exp_run});
		rchk(fdcr_pkg::IDX_SYNC, {30'h0, exp_run});
		wr(fdcr_pkg::IDX_PNCTL, 32'h0);
		repeat (4) @(posedge ref_clk);
		check({30'h0, run}, 32'h0);
		bus(1'b0, fdcr_pkg::IDX_SIG0, 32'h0);
		sa = rd;
		bus(1'b0, fdcr_pkg::IDX_SIG0 + 8'h02, 32'h0);
		sb = rd;
	endtask
	task automatic t_self();
		selfrun(1'b0, 37500, 2'h1);
		sa2 = sa;
		check(sb, fdcr_pkg::SIG_RST);
		check({31'h0, sa === fdcr_pkg::SIG_RST}, 32'h0);
		selfrun(1'b0, 37500, 2'h1);
		check(sa, sa2);
		selfrun(1'b1, 500, 2'h3);
		check({31'h0, sb === fdcr_pkg::SIG_RST}, 32'h0);
	endtask
	initial begin
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_low();
		t_high();
		t_bypass();
		t_self();
		tally_and_finish();
	end
endmodule
